// file: rtl/osc_trim_calibrator.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Count fast oscillator divided by thirty-two.
// - Reference window is sub-clock divided by 1024.
// - Count between successive reference rising edges.
// - Second tick starts four back-to-back measurements.
// - Average four counts as adjustment input.
// - Capture each count at measurement end.
// - Modify trim when difference reaches tolerance.
// - High average decrements trim, low increments.
// - Inside tolerance band trim stays unchanged.
// - Stop measuring after adjustment until next round.
// - Wait for settling until next second tick.
// - All-ones option word: oscillator off after reset.
// - Trim register chosen by oscillator frequency selection.
// - At 32 MHz the theoretical count is 31250.
module osc_trim_calibrator #(
  parameter int unsigned         TRIM_W     = osc_trim_pkg::TRIM_W,
  parameter logic [TRIM_W-1:0]   TRIM_RESET = osc_trim_pkg::TRIM_RESET
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst,
  // Option word and oscillator enable.
  input  wire logic [31:0]       option_word_one,
  input  wire logic              osc_enable_req,
  output logic                   fast_internal_osc_run,
  // Clock sources seen by the measurement.
  input  wire logic              fast_osc_edge,
  input  wire logic              sub_clk_level,
  // Periodic tick from the real-time counter.
  input  wire logic              second_tick,
  // Oscillator frequency selection.
  input  wire logic [1:0]        freq_sel,
  // Trim outputs.
  output logic [TRIM_W-1:0]      fast_osc_trim_32m,
  output logic [TRIM_W-1:0]      fast_osc_trim_sel,
  // Status.
  output logic                   measuring,
  output logic                   settling,
  output logic [15:0]            last_average,
  output logic                   adjust_done
);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  osc_trim_pkg::cal_state_e                state_reg;
  osc_trim_pkg::cal_state_e                state_next;
  logic                                    strap_pending_reg;
  logic                                    sub_clk_d_reg;
  logic                                    sub_rise;
  logic                                    fast_div_pulse;
  logic                                    ref_edge;
  logic [osc_trim_pkg::COUNT_W-1:0]        meas_count_reg;
  logic [osc_trim_pkg::SUM_W-1:0]          sum_reg;
  logic [osc_trim_pkg::MEAS_IDX_W-1:0]     meas_idx_reg;
  logic                                    round_full;
  logic [osc_trim_pkg::SUM_W-1:0]          sum_final;
  logic [15:0]                             average;
  logic signed [osc_trim_pkg::DIFF_W-1:0]  diff;
  logic [TRIM_W-1:0]                       trim_reg [osc_trim_pkg::TRIM_REGS];
  logic [TRIM_W-1:0]                       trim_next;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Theoretical count for a frequency selection.
  function automatic logic [15:0] theo_count(input logic [1:0] sel);
    logic [15:0] val;
    val = osc_trim_pkg::THEO_32M;
    unique case (sel)
      osc_trim_pkg::SEL_32M:    val = osc_trim_pkg::THEO_32M;
      osc_trim_pkg::SEL_36M864: val = osc_trim_pkg::THEO_36M864;
      osc_trim_pkg::SEL_40M:    val = osc_trim_pkg::THEO_40M;
      osc_trim_pkg::SEL_50M:    val = osc_trim_pkg::THEO_50M;
    endcase
    return val;
  endfunction

  // One trim step in either direction, held at the field limits.
  function automatic logic [TRIM_W-1:0] trim_step(input logic [TRIM_W-1:0] cur,
                                                  input logic              up);
    logic [TRIM_W-1:0] res;
    res = cur;
    if (up) begin
      if (cur != {TRIM_W{1'b1}}) begin
        res = cur + TRIM_W'(1);
      end
    end else begin
      if (cur != {TRIM_W{1'b0}}) begin
        res = cur - TRIM_W'(1);
      end
    end
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Oscillator enable.

  always_ff @(posedge clk) begin
    if (rst) begin
      strap_pending_reg     <= 1'b1;
      fast_internal_osc_run <= 1'b0;
    end else begin
      strap_pending_reg <= 1'b0;
      if (strap_pending_reg && (option_word_one != osc_trim_pkg::OPTION_ALL_ONES)) begin
        fast_internal_osc_run <= 1'b1;
      end else if (osc_enable_req) begin
        fast_internal_osc_run <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Clock dividers.

  pulse_divider #(
    .RATIO     (osc_trim_pkg::FAST_DIV_RATIO)
  ) u_fast_div (
    .clk       (clk),
    .rst       (rst),
    .pulse_in  (fast_osc_edge && fast_internal_osc_run),
    .pulse_out (fast_div_pulse)
  );

  // Sub-clock rising edge; the crystal is assumed to keep running.
  always_ff @(posedge clk) begin
    if (rst) begin
      sub_clk_d_reg <= 1'b0;
    end else begin
      sub_clk_d_reg <= sub_clk_level;
    end
  end

  assign sub_rise = sub_clk_level && !sub_clk_d_reg;

  pulse_divider #(
    .RATIO     (osc_trim_pkg::REF_DIV_RATIO)
  ) u_ref_div (
    .clk       (clk),
    .rst       (rst),
    .pulse_in  (sub_rise),
    .pulse_out (ref_edge)
  );

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  assign round_full = (meas_idx_reg == osc_trim_pkg::MEAS_IDX_W'(osc_trim_pkg::MEAS_PER_ROUND - 1));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      osc_trim_pkg::ST_STOPPED: begin
        if (fast_internal_osc_run) begin
          state_next = osc_trim_pkg::ST_WAIT;
        end
      end
      osc_trim_pkg::ST_WAIT: begin
        if (second_tick) begin
          state_next = osc_trim_pkg::ST_ARM;
        end
      end
      osc_trim_pkg::ST_ARM: begin
        if (ref_edge) begin
          state_next = osc_trim_pkg::ST_MEASURE;
        end
      end
      osc_trim_pkg::ST_MEASURE: begin
        if (ref_edge && round_full) begin
          state_next = osc_trim_pkg::ST_ADJUST;
        end
      end
      osc_trim_pkg::ST_ADJUST: begin
        state_next = osc_trim_pkg::ST_SETTLE;
      end
      osc_trim_pkg::ST_SETTLE: begin
        if (second_tick) begin
          state_next = osc_trim_pkg::ST_ARM;
        end
      end
      default: begin
        state_next = osc_trim_pkg::ST_STOPPED;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= osc_trim_pkg::ST_STOPPED;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Edge counting.

  always_ff @(posedge clk) begin
    if (rst) begin
      meas_count_reg <= '0;
    end else if (ref_edge) begin
      meas_count_reg <= osc_trim_pkg::COUNT_W'(fast_div_pulse);
    end else if (state_reg == osc_trim_pkg::ST_MEASURE && fast_div_pulse) begin
      if (meas_count_reg != {osc_trim_pkg::COUNT_W{1'b1}}) begin
        meas_count_reg <= meas_count_reg + osc_trim_pkg::COUNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sum_reg      <= '0;
      meas_idx_reg <= '0;
    end else if (state_reg == osc_trim_pkg::ST_ARM) begin
      sum_reg      <= '0;
      meas_idx_reg <= '0;
    end else if (state_reg == osc_trim_pkg::ST_MEASURE && ref_edge) begin
      sum_reg      <= sum_reg + osc_trim_pkg::SUM_W'(meas_count_reg);
      meas_idx_reg <= meas_idx_reg + osc_trim_pkg::MEAS_IDX_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Adjustment.

  assign sum_final = sum_reg;
  assign average   = 16'(sum_final >> osc_trim_pkg::AVG_SHIFT);

  assign diff = $signed({1'b0, average}) - $signed({1'b0, theo_count(freq_sel)});

  always_comb begin
    trim_next = trim_reg[freq_sel];
    if (diff >= osc_trim_pkg::TOLERANCE_COUNTS) begin
      trim_next = trim_step(trim_reg[freq_sel], 1'b0);
    end else if (diff <= -osc_trim_pkg::TOLERANCE_COUNTS) begin
      trim_next = trim_step(trim_reg[freq_sel], 1'b1);
    end else begin
      trim_next = trim_reg[freq_sel];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < osc_trim_pkg::TRIM_REGS; i++) begin
        trim_reg[i] <= TRIM_RESET;
      end
    end else if (state_reg == osc_trim_pkg::ST_ADJUST) begin
      trim_reg[freq_sel] <= trim_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  always_ff @(posedge clk) begin
    if (rst) begin
      fast_osc_trim_32m <= TRIM_RESET;
      fast_osc_trim_sel <= TRIM_RESET;
    end else begin
      fast_osc_trim_32m <= trim_reg[osc_trim_pkg::SEL_32M];
      fast_osc_trim_sel <= trim_reg[freq_sel];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      measuring    <= 1'b0;
      settling     <= 1'b0;
      adjust_done  <= 1'b0;
      last_average <= '0;
    end else begin
      measuring   <= (state_next == osc_trim_pkg::ST_ARM) ||
                     (state_next == osc_trim_pkg::ST_MEASURE);
      settling    <= (state_next == osc_trim_pkg::ST_SETTLE);
      adjust_done <= (state_reg == osc_trim_pkg::ST_ADJUST);
      if (state_reg == osc_trim_pkg::ST_ADJUST) begin
        last_average <= average;
      end
    end
  end

endmodule

// file: rtl/osc_trim_pkg.sv
package osc_trim_pkg;

  // Divider ratios for the counted clock and the reference window.
  localparam int unsigned FAST_DIV_RATIO = 32;
  localparam int unsigned REF_DIV_RATIO  = 1024;

  // Round shape and tolerance.
  localparam int unsigned MEAS_PER_ROUND = 4;
  localparam int unsigned MEAS_IDX_W     = 2;
  localparam int unsigned AVG_SHIFT      = 2;
  localparam int unsigned COUNT_W        = 16;
  localparam int unsigned SUM_W          = 18;
  localparam int unsigned DIFF_W         = 17;
  localparam logic signed [16:0] TOLERANCE_COUNTS = 17'sh00100;

  // Theoretical counts per oscillator frequency selection.
  localparam logic [15:0] THEO_32M     = 16'h7a12;
  localparam logic [15:0] THEO_36M864  = 16'h8ca0;
  localparam logic [15:0] THEO_40M     = 16'h9896;
  localparam logic [15:0] THEO_50M     = 16'hbebc;

  // Frequency selection codes.
  localparam logic [1:0] SEL_32M     = 2'h0;
  localparam logic [1:0] SEL_36M864  = 2'h1;
  localparam logic [1:0] SEL_40M     = 2'h2;
  localparam logic [1:0] SEL_50M     = 2'h3;
  localparam int unsigned TRIM_REGS  = 4;

  // Option word value that leaves the oscillator stopped after reset.
  localparam logic [31:0] OPTION_ALL_ONES = 32'hffff_ffff;

  // Trim field.
  localparam int unsigned TRIM_W          = 8;
  localparam logic [7:0]  TRIM_RESET      = 8'h80;
  localparam logic [7:0]  TRIM_MIN        = 8'h00;
  localparam logic [7:0]  TRIM_MAX        = 8'hff;

  // Calibration sequencer states, Gray coded from ST_STOPPED through ST_SETTLE; ST_SETTLE back to ST_ARM changes all three bits.
  typedef enum logic [2:0] {
    ST_STOPPED = 3'b100,
    ST_WAIT    = 3'b000,
    ST_ARM     = 3'b001,
    ST_MEASURE = 3'b011,
    ST_ADJUST  = 3'b010,
    ST_SETTLE  = 3'b110
  } cal_state_e;

endpackage

// file: rtl/pulse_divider.sv
`timescale 1ns/10ps
module pulse_divider #(
  parameter int unsigned RATIO = 32
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Input events and divided output event.
  input  wire logic pulse_in,
  output logic      pulse_out
);

  localparam int unsigned CNT_W = (RATIO > 1) ? $clog2(RATIO) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(RATIO - 1);

  logic [CNT_W-1:0] cnt_reg;

  // Counts input events and wraps once per ratio.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (pulse_in) begin
      if (cnt_reg == LAST) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end
    end
  end

  // The output rises once on each wrap.
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= pulse_in && (cnt_reg == LAST);
    end
  end

endmodule

// file: verif/osc_model.sv
`timescale 1ns/10ps
module osc_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Oscillator control.
  input  wire logic       run,
  input  wire logic [3:0] gap,
  // Clock sources.
  output logic            fast_osc_edge,
  output logic            sub_clk_level
);
  logic [3:0] cnt_reg;
  always_ff @(posedge clk) begin
    sub_clk_level <= rst ? 1'b0 : ~sub_clk_level;
  end
  always_ff @(posedge clk) begin
    fast_osc_edge <= !rst && run && cnt_reg == 4'h0;
    cnt_reg       <= (rst || cnt_reg + 4'h1 >= gap) ? 4'h0 : cnt_reg + 4'h1;
  end
endmodule

// file: verif/osc_trim_checker_asserts.sv
`timescale 1ns/10ps
module osc_trim_checker #(
  parameter int unsigned TRIM_W = 8
) (
  // Clock and reset.
  input wire logic              clk,
  input wire logic              rst,
  // Watched ports.
  input wire logic              fast_internal_osc_run,
  input wire logic              second_tick,
  input wire logic [1:0]        freq_sel,
  input wire logic [TRIM_W-1:0] fast_osc_trim_32m,
  input wire logic [TRIM_W-1:0] fast_osc_trim_sel,
  input wire logic              measuring,
  input wire logic              settling,
  input wire logic [15:0]       last_average,
  input wire logic              adjust_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic at32;
  logic low;
  logic high;
  assign at32 = adjust_done && freq_sel == osc_trim_pkg::SEL_32M;
  assign low  = {1'b0, last_average} + 17'h00100 <= {1'b0, osc_trim_pkg::THEO_32M};
  assign high = {1'b0, last_average} >= {1'b0, osc_trim_pkg::THEO_32M} + 17'h00100;
  a_tick_start: assert property ((second_tick && settling) |=> measuring)
    else $error("tick did not start a round");
  a_done_settles: assert property (adjust_done |-> settling && !measuring)
    else $error("not settling at adjust");
  a_done_single: assert property (adjust_done |=> !adjust_done)
    else $error("adjust pulse too long");
  a_avg_at_adjust: assert property ($changed(last_average) |-> adjust_done)
    else $error("average moved outside adjust");
  a_trim_unit: assert property ($changed(fast_osc_trim_32m) |-> $past(adjust_done) &&
    (fast_osc_trim_32m == $past(fast_osc_trim_32m) + 1'b1 ||
     fast_osc_trim_32m == $past(fast_osc_trim_32m) - 1'b1))
    else $error("trim step not one");
  a_low_inc: assert property (at32 && low && fast_osc_trim_32m != '1
    |=> fast_osc_trim_32m == $past(fast_osc_trim_32m) + 1'b1)
    else $error("low average did not raise trim");
  a_high_dec: assert property (at32 && high && fast_osc_trim_32m != '0
    |=> fast_osc_trim_32m == $past(fast_osc_trim_32m) - 1'b1)
    else $error("high average did not lower trim");
  a_band_hold: assert property (at32 && !low && !high |=> $stable(fast_osc_trim_32m))
    else $error("trim moved inside band");
  a_meas_stop: assert property ($fell(measuring) |-> ##[0:2] adjust_done)
    else $error("measuring ended without adjust");
  a_osc_sticky: assert property (fast_internal_osc_run |=> fast_internal_osc_run)
    else $error("oscillator dropped");
  a_off_idle: assert property (!fast_internal_osc_run |-> !measuring && !settling)
    else $error("active while oscillator off");
  a_sel_mux: assert property ($past(freq_sel) == osc_trim_pkg::SEL_32M &&
    !adjust_done |-> fast_osc_trim_sel == fast_osc_trim_32m)
    else $error("trim selection wrong");
  c_adjust: cover property (adjust_done);
  c_tick_settle: cover property (second_tick && settling);
  c_osc_on: cover property ($rose(fast_internal_osc_run));
endmodule
bind osc_trim_calibrator osc_trim_checker #(.TRIM_W(TRIM_W)) i_chk (
  .clk, .rst, .fast_internal_osc_run, .second_tick, .freq_sel, .fast_osc_trim_32m,
  .fast_osc_trim_sel, .measuring, .settling, .last_average, .adjust_done
);

// file: verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        clk            = 1'b0;
  logic        rst            = 1'b1;
  logic        osc_enable_req = 1'b0;
  logic        second_tick    = 1'b0;
  logic [31:0] option_word_one = 32'hffff_ffff;
  logic [1:0]  freq_sel       = 2'h0;
  logic [3:0]  gap            = 4'h1;
  logic        fast_osc_edge, sub_clk_level, fast_internal_osc_run;
  logic        measuring, settling, adjust_done;
  logic [7:0]  fast_osc_trim_32m, fast_osc_trim_sel;
  logic [15:0] last_average;
  logic [7:0]  exp_trim [4];
  int          n_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;

  always #5 clk = ~clk;

  osc_trim_calibrator i_dut (.clk, .rst, .option_word_one, .osc_enable_req,
    .fast_internal_osc_run, .fast_osc_edge, .sub_clk_level, .second_tick, .freq_sel,
    .fast_osc_trim_32m, .fast_osc_trim_sel, .measuring, .settling, .last_average,
    .adjust_done);
  osc_model i_osc (.clk, .rst, .run(fast_internal_osc_run), .gap, .fast_osc_edge,
    .sub_clk_level);

  task automatic wrap_up;
    $display("Counts: %0d errors in %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check_bit(input logic act, input logic exp, input string what);
    tests_run++;
    if (act !== exp) begin
      n_errors++;
      $display("Error %0t: %s", $time, what);
    end
  endtask

  task automatic check_val(input logic [15:0] act, input logic [15:0] exp, input string what);
    tests_run++;
    if (act !== exp) begin
      n_errors++;
      $display("Error %0t: %s got %h want %h", $time, what, act, exp);
    end
  endtask

  task automatic pulse_tick;
    @(posedge clk) second_tick <= 1'b1;
    @(posedge clk) second_tick <= 1'b0;
  endtask

  task automatic t_osc_off;
    pulse_tick();
    repeat (20) @(posedge clk);
    #1 check_bit(fast_internal_osc_run, 1'b0, "oscillator ran");
    check_bit(measuring, 1'b0, "round while off");
    @(posedge clk) osc_enable_req <= 1'b1;
    @(posedge clk) osc_enable_req <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check_bit(fast_internal_osc_run, 1'b1, "enable ignored");
    $display("t_osc_off done");
  endtask

  task automatic t_round(input logic [1:0] sel, input logic [3:0] g);
    int n;
    @(posedge clk) freq_sel <= sel;
    gap <= g;
    repeat (3) @(posedge clk);
    #1 check_val({8'h00, fast_osc_trim_sel}, {8'h00, exp_trim[sel]}, "selected trim");
    pulse_tick();
    @(posedge clk);
    #1 check_bit(measuring, 1'b1, "round not started");
    repeat (100) @(posedge clk);
    pulse_tick();
    n = 0;
    while (adjust_done !== 1'b1 && n < 12000) begin
      @(posedge clk);
      #1 n++;
    end
    exp_trim[sel] = exp_trim[sel] + 8'h01;
    check_bit(n > 8000 && n < 10300, 1'b1, "round length");
    check_val(last_average, 16'h0040 / {12'h000, g}, "average");
    @(posedge clk);
    #1 check_val({8'h00, fast_osc_trim_sel}, {8'h00, exp_trim[sel]}, "stepped trim");
    check_val({8'h00, fast_osc_trim_32m}, {8'h00, exp_trim[0]}, "trim 32m");
    repeat (20) @(posedge clk);
    #1 check_bit(measuring, 1'b0, "still measuring");
    check_bit(settling, 1'b1, "not settling");
    $display("t_round %0d done", sel);
  endtask

  task automatic t_reset;
    @(posedge clk) rst <= 1'b1;
    option_word_one <= 32'h0000_0000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1 check_bit(fast_internal_osc_run, 1'b1, "oscillator off");
    check_val({8'h00, fast_osc_trim_32m}, 16'h0080, "trim reset");
    $display("t_reset done");
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 70000) begin
      n_errors++;
      $display("Error %0t: timeout", $time);
      wrap_up();
    end
  end

  initial begin
    for (int i = 0; i < 4; i++) exp_trim[i] = 8'h80;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_osc_off();
    t_round(osc_trim_pkg::SEL_32M, 4'h1);
    t_round(osc_trim_pkg::SEL_36M864, 4'h2);
    t_round(osc_trim_pkg::SEL_40M, 4'h4);
    t_round(osc_trim_pkg::SEL_50M, 4'h2);
    t_reset();
    wrap_up();
  end
endmodule
